// *** rtl/fast_counter_pkg.sv ***
// package of constants and types for the fast input counter block
package fast_counter_pkg;

	// ************************************************************
	// channel count, widths and timing
	// ************************************************************
	localparam int            channel_count     = 4;
	localparam int            accum_width       = 32;
	localparam int            clock_hz          = 10_000_000;
	localparam int            sample_tick_ns    = 1000;
	localparam int            clock_period_ns   = 1_000_000_000 / clock_hz;
	localparam int            tick_cycles       = (sample_tick_ns + clock_period_ns - 1) / clock_period_ns;
	localparam int            min_edge_gap_us   = 100;
	localparam int            reset_value       = 0;

	// frequency window lengths in 1 us ticks, one per window selection
	localparam logic [31:0]   window_ticks_0    = 32'h0000_2710;
	localparam logic [31:0]   window_ticks_1    = 32'h0000_61a8;
	localparam logic [31:0]   window_ticks_2    = 32'h0000_c350;
	localparam logic [31:0]   window_ticks_3    = 32'h000f_4240;
	// window multiplier turning counts per window into hertz
	localparam logic [31:0]   window_scale_0    = 32'h0000_0064;
	localparam logic [31:0]   window_scale_1    = 32'h0000_0028;
	localparam logic [31:0]   window_scale_2    = 32'h0000_0014;
	localparam logic [31:0]   window_scale_3    = 32'h0000_0001;

	// ************************************************************
	// register map (avalon word addresses = byte offset / 4)
	// ************************************************************
	localparam logic [5:0]    ofs_mode_0        = 6'h00;
	localparam logic [5:0]    ofs_wrap_0        = 6'h04;
	localparam logic [5:0]    ofs_result_0      = 6'h08;
	localparam logic [5:0]    ofs_control       = 6'h20;
	localparam logic [5:0]    ofs_status        = 6'h21;
	localparam int            channel_stride    = 1;

	// mode register field positions
	localparam int            mode_lsb          = 0;
	localparam int            sub_lsb           = 3;
	localparam int            edge_bit          = 5;
	localparam int            window_lsb        = 6;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		mode_off        = 3'h0,
		mode_frequency  = 3'h1,
		mode_totalize   = 3'h2,
		mode_pulse      = 3'h3,
		mode_quadrature = 3'h4
	} measure_mode_type;

	typedef enum logic [1:0] {
		pulse_high      = 2'h0,
		pulse_low       = 2'h1,
		period_rise     = 2'h2,
		period_fall     = 2'h3
	} pulse_sub_type;

	typedef struct packed {
		logic [1:0]       window;
		logic             edge_fall;
		pulse_sub_type    sub;
		measure_mode_type mode;
	} channel_config_type;

	typedef struct packed {
		logic             clear;
		logic             disable_count;
		logic             hold_reset;
		logic             load_wrap;
	} channel_control_type;

endpackage

// *** rtl/fast_counter_lane.sv ***
// one measurement channel of the fast input counter
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fast_counter_lane
	import fast_counter_pkg::*;
(
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// sampled inputs
	input  wire logic                      tick,
	input  wire logic                      level_a,
	input  wire logic                      level_b,
	input  wire logic                      lane_used,
	// configuration and control
	input  wire channel_config_type        config_word,
	input  wire logic [accum_width-1:0]    wrap_value,
	input  wire channel_control_type       control,
	input  wire logic                      ext_reset,
	// result
	output logic [accum_width-1:0]         result
);

	logic                    prev_a;
	logic                    prev_b;
	logic [accum_width-1:0]  width_count;
	logic [accum_width-1:0]  window_count;
	logic [accum_width-1:0]  edge_count;
	logic                    measuring;
	logic                    rise_a;
	logic                    fall_a;
	logic                    edge_a;
	logic                    edge_b;
	logic                    count_edge;
	logic                    quad_up;
	logic [accum_width-1:0]  window_len;
	logic [accum_width-1:0]  window_div;
	logic                    counting_mode;
	logic                    zero_hold;

	// ************************************************************
	// edge detection on the 1 us tick
	// ************************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
		end else if (tick) begin
			prev_a <= level_a;
			prev_b <= level_b;
		end
	end

	// edges exist only on a tick
	assign rise_a     = tick & level_a & ~prev_a;
	assign fall_a     = tick & ~level_a & prev_a;
	assign edge_a     = rise_a | fall_a;
	assign edge_b     = tick & (level_b ^ prev_b);
	// edge select is positive logic whatever the input polarity
	assign count_edge = config_word.edge_fall ? fall_a : rise_a;
	// a leads b counts up; edge_fall flips the sense
	assign quad_up    = (edge_a ? (level_a ^ level_b) : ~(level_a ^ level_b))
	                    ^ config_word.edge_fall;

	// frequency window length and scaling per selection
	always_comb begin
		case (config_word.window)
		2'h0: begin
			window_len = window_ticks_0;
			window_div = window_scale_0;
		end
		2'h1: begin
			window_len = window_ticks_1;
			window_div = window_scale_1;
		end
		2'h2: begin
			window_len = window_ticks_2;
			window_div = window_scale_2;
		end
		default: begin
			window_len = window_ticks_3;
			window_div = window_scale_3;
		end
		endcase
	end

	// clear applies to counting modes only
	assign counting_mode = (config_word.mode == mode_totalize)
	                       | (config_word.mode == mode_quadrature);
	assign zero_hold     = counting_mode & (control.clear | control.hold_reset | ext_reset);

	// ************************************************************
	// frequency: edges per window, scaled to hertz
	// ************************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			window_count <= '0;
			edge_count   <= '0;
		end else if (config_word.mode != mode_frequency || !lane_used) begin
			window_count <= '0;
			edge_count   <= '0;
		end else if (tick) begin
			if (window_count >= window_len - 32'h0000_0001) begin
				window_count <= '0;
				edge_count   <= '0;
			end else begin
				window_count <= window_count + 32'h0000_0001;
				edge_count   <= edge_count + {31'h0, rise_a};
			end
		end
	end

	// ************************************************************
	// pulse width and period timer
	// ************************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			width_count <= '0;
			measuring   <= 1'b0;
		end else if (config_word.mode != mode_pulse || !lane_used) begin
			width_count <= '0;
			measuring   <= 1'b0;
		end else if (tick) begin
			case (config_word.sub)
			pulse_high: begin
				measuring   <= rise_a | (measuring & ~fall_a);
				width_count <= rise_a ? 32'h0000_0001 : width_count + 32'h0000_0001;
			end
			pulse_low: begin
				measuring   <= fall_a | (measuring & ~rise_a);
				width_count <= fall_a ? 32'h0000_0001 : width_count + 32'h0000_0001;
			end
			period_rise: begin
				measuring   <= 1'b1;
				width_count <= rise_a ? 32'h0000_0001 : width_count + 32'h0000_0001;
			end
			default: begin
				measuring   <= 1'b1;
				width_count <= fall_a ? 32'h0000_0001 : width_count + 32'h0000_0001;
			end
			endcase
		end
	end

	// ************************************************************
	// result register
	// ************************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			result <= '0;
		end else if (!lane_used) begin
			result <= '0;
		end else if (zero_hold) begin
			result <= '0;
		end else if (control.load_wrap && config_word.mode == mode_quadrature) begin
			result <= wrap_value - 32'h0000_0001;
		end else begin
			case (config_word.mode)
			mode_frequency: begin
				if (tick && window_count >= window_len - 32'h0000_0001)
					result <= (edge_count + {31'h0, rise_a}) * window_div;
			end
			mode_totalize: begin
				if (count_edge && !control.disable_count) begin
					if (wrap_value != '0 && result >= wrap_value - 32'h0000_0001)
						result <= '0;
					else
						result <= result + 32'h0000_0001;
				end
			end
			mode_pulse: begin
				// hold last complete measurement
				case (config_word.sub)
				pulse_high: if (measuring && fall_a) result <= width_count;
				pulse_low: if (measuring && rise_a) result <= width_count;
				period_rise: if (rise_a && measuring) result <= width_count;
				default: if (fall_a && measuring) result <= width_count;
				endcase
			end
			mode_quadrature: begin
				if ((edge_a || edge_b) && !control.disable_count) begin
					if (quad_up) begin
						if (wrap_value != '0 && result >= wrap_value - 32'h0000_0001)
							result <= '0;
						else
							result <= result + 32'h0000_0001;
					end else begin
						if (wrap_value != '0 && result == '0)
							result <= wrap_value - 32'h0000_0001;
						else
							result <= result - 32'h0000_0001;
					end
				end
			end
			default: result <= '0;
			endcase
		end
	end

endmodule
`default_nettype wire

// *** rtl/fast_counter.sv ***
// top of the four channel fast input counter with avalon slave
// Operation
// - four inputs, each frequency/totalize/pulse/quadrature
// - some modes claim a neighbour input
// - each result readable as measurement word
// - 1 us resolution; source keeps 100 us gaps
// - edge select is positive logic always
// - frequency mode reports hertz
// - four selectable frequency windows
// - totalize counts selected rising or falling edge
// - totalize reset by three separate means
// - clear zeroes; not in frequency/pulse
// - disable stops counting while set
// - wrap at N-1, zero means 32-bit
// - level reset bit holds total at zero
// - pulse reports widths or periods in us
// - quadrature counts four edges, direction sensed
`timescale 1ns/10ps
`default_nettype none
module fast_counter
	import fast_counter_pkg::*;
#(
	parameter int channels = channel_count
)
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset,
	// counter input pins
	input  wire logic [channels-1:0]     counter_pin,
	// avalon-mm slave
	input  wire logic [5:0]              avs_address,
	input  wire logic                    avs_read,
	input  wire logic                    avs_write,
	input  wire logic [31:0]             avs_writedata,
	input  wire logic [3:0]              avs_byteenable,
	output logic [31:0]                  avs_readdata,
	output logic                         avs_waitrequest
);

	localparam int tick_width = $clog2(tick_cycles + 1);

	logic [channels-1:0]              sync_1;
	logic [channels-1:0]              sync_2;
	logic [tick_width-1:0]            tick_count;
	logic                             tick;
	channel_config_type               config_reg [channels];
	logic [accum_width-1:0]           wrap_reg [channels];
	logic [accum_width-1:0]           measurement_result_word [channels];
	channel_control_type              control_reg [channels];
	logic [channels-1:0]              lane_used;
	logic [channels-1:0]              ext_reset;
	logic [channels-1:0]              prev_pin;
	logic                             answered;
	logic [31:0]                      next_readdata;
	logic [31:0]                      byte_mask;

	// ************************************************************
	// input synchroniser and 1 us sampling tick
	// ************************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sync_1 <= '0;
			sync_2 <= '0;
		end else begin
			sync_1 <= counter_pin;
			sync_2 <= sync_1;
		end
	end

	// tick every microsecond
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			tick_count <= '0;
		end else if (tick) begin
			tick_count <= '0;
		end else begin
			tick_count <= tick_count + 1'b1;
		end
	end
	assign tick = (tick_count == tick_width'(tick_cycles - 1));

	// ************************************************************
	// input ownership and external reset edges
	// ************************************************************
	// quadrature on even channel k claims k+1; totalize on k may use k+2 as reset
	always_comb begin
		lane_used = '1;
		ext_reset = '0;
		for (int k = 0; k < channels; k++) begin
			if (k % 2 == 0 && k + 1 < channels && config_reg[k].mode == mode_quadrature)
				lane_used[k+1] = 1'b0;
			if (k + 2 < channels && config_reg[k].mode == mode_totalize
			    && config_reg[k+2].mode == mode_off) begin
				lane_used[k+2] = 1'b0;
				ext_reset[k]   = tick & (config_reg[k+2].edge_fall
				                 ? (prev_pin[k+2] & ~sync_2[k+2])
				                 : (~prev_pin[k+2] & sync_2[k+2]));
			end
		end
	end

	// previous sampled level for the reset inputs
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prev_pin <= '0;
		end else if (tick) begin
			prev_pin <= sync_2;
		end
	end

	// ************************************************************
	// channel lanes
	// ************************************************************
	generate
		for (genvar g = 0; g < channels; g++) begin : lane
			fast_counter_lane u_lane (
				.clk         (clk),
				.reset       (reset),
				.tick        (tick),
				.level_a     (sync_2[g]),
				.level_b     (sync_2[(g + 1) % channels]),
				.lane_used   (lane_used[g]),
				.config_word (config_reg[g]),
				.wrap_value  (wrap_reg[g]),
				.control     (control_reg[g]),
				.ext_reset   (ext_reset[g]),
				.result      (measurement_result_word[g])
			);
		end
	endgenerate

	// ************************************************************
	// avalon register file
	// ************************************************************
	// byte enables widened to a bit mask
	always_comb begin
		for (int b = 0; b < 4; b++)
			byte_mask[b*8 +: 8] = {8{avs_byteenable[b]}};
	end

	// configuration writes
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int k = 0; k < channels; k++) begin
				config_reg[k]  <= '0;
				wrap_reg[k]    <= '0;
				control_reg[k] <= '0;
			end
		end else if (avs_write && !avs_waitrequest) begin
			for (int k = 0; k < channels; k++) begin
				if (avs_address == ofs_mode_0 + 6'(k))
					config_reg[k] <= channel_config_type'(
						(config_reg[k] & ~byte_mask[7:0]) | (avs_writedata[7:0] & byte_mask[7:0]));
				if (avs_address == ofs_wrap_0 + 6'(k))
					wrap_reg[k] <= (wrap_reg[k] & ~byte_mask) | (avs_writedata & byte_mask);
				if (avs_address == ofs_control && avs_byteenable[k])
					control_reg[k] <= channel_control_type'(avs_writedata[k*8 +: 4]);
			end
		end
	end

	// read multiplexer; unmapped reads return zero
	always_comb begin
		next_readdata = '0;
		for (int k = 0; k < channels; k++) begin
			if (avs_address == ofs_mode_0 + 6'(k))
				next_readdata = 32'(config_reg[k]);
			if (avs_address == ofs_wrap_0 + 6'(k))
				next_readdata = wrap_reg[k];
			if (avs_address == ofs_result_0 + 6'(k))
				next_readdata = measurement_result_word[k];
			if (avs_address == ofs_control)
				next_readdata[k*8 +: 4] = control_reg[k];
			if (avs_address == ofs_status)
				next_readdata[k] = lane_used[k];
		end
	end

	// one wait cycle then answer, registered read data
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			answered     <= 1'b0;
			avs_readdata <= '0;
		end else if ((avs_read || avs_write) && !answered) begin
			answered     <= 1'b1;
			avs_readdata <= next_readdata;
		end else begin
			answered     <= 1'b0;
		end
	end
	assign avs_waitrequest = (avs_read || avs_write) && !answered;

endmodule
`default_nettype wire

// *** tb/fast_counter_assertions.sv ***
// checker of bus timing and register behaviour of the fast counter
`timescale 1ns/10ps
`default_nettype none
module fast_counter_check
	import fast_counter_pkg::*;
#(
	parameter int channels = channel_count
)
(
	// clock and reset
	input wire logic                clk,
	input wire logic                reset,
	// pins and bus
	input wire logic [channels-1:0] counter_pin,
	input wire logic [5:0]          avs_address,
	input wire logic                avs_read,
	input wire logic                avs_write,
	input wire logic [31:0]         avs_writedata,
	input wire logic [3:0]          avs_byteenable,
	input wire logic [31:0]         avs_readdata,
	input wire logic                avs_waitrequest
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	logic [31:0] shadow [8];
	logic [3:0]  held;
	logic [3:0]  held_d;
	logic        rd_ok;
	logic        wr_ok;
	logic        busy;
	assign busy  = avs_read || avs_write;
	assign rd_ok = avs_read && !avs_waitrequest;
	assign wr_ok = avs_write && !avs_waitrequest;
	// shadow of setup words written
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			shadow <= '{default: '0};
		end else if (wr_ok && avs_address < 6'h08) begin
			shadow[avs_address[2:0]] <= avs_writedata;
		end
	end
	// level reset bits, and their age
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			held <= '0;
			held_d <= '0;
		end else begin
			held_d <= held;
			if (wr_ok && avs_address == ofs_control) begin
				held <= {avs_writedata[25], avs_writedata[17], avs_writedata[9], avs_writedata[1]};
			end
		end
	end
	property p_wait_first;
		$rose(busy) |-> avs_waitrequest;
	endproperty
	a_wait_first: assert property (p_wait_first) else $error("no wait on new request");
	property p_wait_once;
		avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_wait_once: assert property (p_wait_once) else $error("wait longer than one cycle");
	property p_answer;
		(avs_read || avs_write) |-> ##[0:1] !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer) else $error("request not answered");
	property p_unmapped;
		rd_ok && (avs_address > ofs_status || (avs_address > 6'h0b && avs_address < ofs_control))
			|-> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_cfg_back;
		rd_ok && avs_address < 6'h04 |-> avs_readdata[7:0] == shadow[avs_address[2:0]][7:0];
	endproperty
	a_cfg_back: assert property (p_cfg_back) else $error("mode word readback wrong");
	property p_wrap_back;
		rd_ok && avs_address[5:2] == 4'h1 |-> avs_readdata == shadow[avs_address[2:0]];
	endproperty
	a_wrap_back: assert property (p_wrap_back) else $error("wrap word readback wrong");
	property p_hold;
		rd_ok && avs_address[5:2] == 4'h2 && held[avs_address[1:0]] && held_d[avs_address[1:0]]
			&& shadow[avs_address[2:0]][2:0] inside {3'h2, 3'h4}
			|-> avs_readdata == 32'h0;
	endproperty
	a_hold: assert property (p_hold) else $error("held total not zero");
	property p_claim;
		rd_ok && avs_address == ofs_status && shadow[0][2:0] == 3'h4 |-> !avs_readdata[1];
	endproperty
	a_claim: assert property (p_claim) else $error("claimed lane shown free");
	property p_stands;
		!busy && !$past(busy) |-> $stable(avs_readdata);
	endproperty
	a_stands: assert property (p_stands) else $error("read data moved while idle");
endmodule
bind fast_counter fast_counter_check #(.channels(channels)) check_u (
	.clk(clk), .reset(reset), .counter_pin(counter_pin), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest));
`default_nettype wire

// *** tb/pulse_source.sv ***
// pulse and encoder source driving the counter inputs
`timescale 1ns/10ps
`default_nettype none
module pulse_source
	import fast_counter_pkg::*;
(
	// clock
	input wire logic                 clk,
	// counter pins
	output logic [channel_count-1:0] pin
);
	initial pin = '0;
	// wait whole microseconds on clock edges
	task automatic gap(input int n);
		repeat (n * tick_cycles) @(posedge clk);
	endtask
	// pulse the masked pins, edges kept apart
	task automatic pulses(input logic [3:0] m, input int n, input int hi, input int lo);
		repeat (n) begin
			pin <= pin | m;
			gap(hi);
			pin <= pin & ~m;
			gap(lo);
		end
	endtask
	// quadrature steps on pins 0 and 1, pin 0 leads when up
	task automatic quad(input int n, input logic up);
		repeat (n) begin
			pin[1:0] <= up ? {pin[0], ~pin[1]} : {~pin[0], pin[1]};
			gap(min_edge_gap_us + 10);
		end
	endtask
endmodule
`default_nettype wire

// *** tb/high_speed_input_counter_test.sv ***
// self-checking bench of the fast counter
`timescale 1ns/10ps
`default_nettype none
module high_speed_input_counter_test
	import fast_counter_pkg::*;
;
	logic        clk;
	logic        reset;
	logic [3:0]  pin;
	logic [5:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [31:0] q;
	logic [7:0]  cfg;
	int          errors = 0;
	int          samples_checked = 0;
	int          n;
	// clock and parts
	initial clk = 1'b0;
	always #50 clk = ~clk;
	fast_counter dut_u (.clk(clk), .reset(reset), .counter_pin(pin),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
	pulse_source src_u (.clk(clk), .pin(pin));
	// compare a seen value with the expected one
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one transfer, held until waitrequest drops
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int k;
		k = 0;
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		chk(32'(k), 32'h2);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask
	// read and compare the masked bits
	task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q & m, e);
	endtask
	// pulse the clear bit of channel 0
	task automatic clr();
		bus(1'b1, ofs_control, 32'h8);
		bus(1'b1, ofs_control, 32'h0);
	endtask
	// total after wrapping at w
	function automatic logic [31:0] wrapped(input int c, input int w);
		return (w == 0) ? c : c % w;
	endfunction
	// pulse result for a sub mode
	function automatic int span(input int s, input int hi, input int lo);
		return (s == 0) ? hi : (s == 1) ? lo : hi + lo;
	endfunction
	// within two ticks of the expected width
	function automatic logic near(input logic [31:0] v, input int e);
		return (v >= 32'(e - 2)) && (v <= 32'(e + 2));
	endfunction
	// verdict and end of run
	task automatic results();
		if (errors == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (100000) @(posedge clk);
		errors++;
		results();
	end
	// main sequence
	initial begin
		void'($urandom(45));
		reset = 1'b1;
		avs_address = 6'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		// reset values, unmapped place ignored
		for (int a = 0; a < 12; a++) rd(6'(a), '1, 32'h0);
		bus(1'b1, 6'h30, $urandom());
		rd(6'h30, '1, 32'h0);
		// every mode stored with random fields
		for (int m = 0; m < 5; m++) begin
			cfg = {5'($urandom_range(31)), 3'(m)};
			bus(1'b1, 6'(m % 4), {24'h0, cfg});
			rd(6'(m % 4), '1, {24'h0, cfg});
		end
		// totalize rising on ch0, falling on ch1
		bus(1'b1, 6'h00, 32'h02);
		bus(1'b1, 6'h01, 32'h22);
		bus(1'b1, 6'h02, 32'h03);
		bus(1'b1, 6'h03, 32'h03);
		src_u.pulses(4'h3, 5, 110, 110);
		rd(ofs_result_0, '1, 32'h5);
		rd(6'h09, '1, 32'h5);
		bus(1'b1, ofs_control, 32'h400);
		src_u.pulses(4'h3, 3, 110, 110);
		rd(ofs_result_0, '1, 32'h8);
		rd(6'h09, '1, 32'h5);
		clr();
		rd(ofs_result_0, '1, 32'h0);
		bus(1'b1, ofs_control, 32'h2);
		src_u.pulses(4'h1, 2, 110, 110);
		rd(ofs_result_0, '1, 32'h0);
		bus(1'b1, ofs_control, 32'h0);
		bus(1'b1, 6'h02, 32'h0);
		src_u.pulses(4'h1, 2, 110, 110);
		rd(ofs_result_0, '1, 32'h2);
		src_u.pulses(4'h4, 1, 110, 110);
		rd(ofs_result_0, '1, 32'h0);
		// wrap at a small count
		n = $urandom_range(5, 1);
		bus(1'b1, ofs_wrap_0, 32'h3);
		clr();
		src_u.pulses(4'h1, n, 110, 110);
		rd(ofs_result_0, '1, wrapped(n, 3));
		// every pulse sub mode on ch3
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, 6'h03, 32'(8 * s + 3));
			src_u.pulses(4'h8, 2, 150, 110);
			bus(1'b0, 6'h0b, 32'h0);
			chk({31'h0, near(q, span(s, 150, 110))}, 32'h1);
		end
		// quadrature up then down on pins 0 and 1
		bus(1'b1, ofs_wrap_0, 32'h0);
		bus(1'b1, 6'h00, 32'h04);
		clr();
		src_u.quad(8, 1'b1);
		rd(ofs_result_0, '1, 32'h8);
		rd(ofs_status, 32'h2, 32'h0);
		src_u.quad(3, 1'b0);
		rd(ofs_result_0, '1, 32'h5);
		results();
	end
endmodule
`default_nettype wire
